// File: bench/iealp_checker.sv
// Port-level assertions for the interrupt enable and low-power block.
`timescale 1ns/1ps
`include "iealp_params.svh"
module iealp_checker #(
    parameter int PHASES = `IEALP_PHASES
) (
    input wire logic       i_clk_sys,
    input wire logic       i_resetn,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic       i_wr,
    input wire logic       i_rd,
    input wire logic [7:0] o_rdata,
    input wire logic [5:0] o_irq_req,
    input wire logic       o_cpu_run,
    input wire logic       o_osc_run,
    input wire logic       o_int_clk,
    input wire logic       o_ram_wr_block,
    input wire logic       o_addr_strobe,
    input wire logic       o_program_store_strobe,
    input wire logic       o_port0_oe,
    input wire logic       o_port2_addr_sel
);
    logic [7:0] ie_q;  // Bus-side mirror of the enable register.
    logic       ext_q; // Mirror of the external program memory select.
    logic [7:0] blk_q; // Cycles the RAM write block has stood so far.
    // The mirrors follow bus writes, so the design is judged against software's view.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            ie_q  <= 8'h00;
            ext_q <= 1'b0;
        end
        else if (i_wr && i_addr == `IEALP_ADDR_IE)
            ie_q  <= i_wdata;
        else if (i_wr && i_addr == `IEALP_ADDR_PCTL)
            ext_q <= i_wdata[2];
    end
    // A counter bounds the block window; a long repetition would slow the tools.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn || !o_ram_wr_block)
            blk_q <= 8'h00;
        else
            blk_q <= blk_q + 8'h01;
    end
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_resetn);
    gate_mask_a: assert property ((o_irq_req & ~$past(ie_q[5:0])) == 6'h00)
        else $error("request raised for a disabled source");
    global_gate_a: assert property (|o_irq_req |-> $past(ie_q[7]))
        else $error("request raised with the global enable off");
    ie_read_a: assert property (i_rd && i_addr == `IEALP_ADDR_IE |=> o_rdata == (ie_q & `IEALP_IE_MASK))
        else $error("enable register read back wrong");
    reset_vals_a: assert property (!$past(i_resetn) |-> o_irq_req == 6'h00 && o_cpu_run && o_osc_run)
        else $error("outputs not reinitialised by reset");
    idle_pins_a: assert property (!o_cpu_run && o_osc_run |-> o_addr_strobe && o_program_store_strobe)
        else $error("strobes not high in idle");
    pdown_pins_a: assert property (!o_osc_run |-> !o_addr_strobe && !o_program_store_strobe && !o_cpu_run)
        else $error("strobes or core running in power-down");
    pdown_hold_a: assert property (!o_osc_run |=> !o_osc_run)
        else $error("power-down left without reset");
    idle_wake_a: assert property (!o_cpu_run && o_osc_run && |o_irq_req |-> ##[1:2] o_cpu_run)
        else $error("enabled request did not end idle");
    port_float_a: assert property (!o_cpu_run && ext_q |-> !o_port0_oe && o_port2_addr_sel == o_osc_run)
        else $error("port state wrong in low power");
    int_clk_a: assert property ($past(i_resetn) && $past(i_resetn, 2) && $past(o_osc_run) && o_osc_run
        |-> o_int_clk != $past(o_int_clk))
        else $error("internal clock not divided by two");
    ram_block_a: assert property (o_ram_wr_block |-> o_cpu_run && int'(blk_q) < 2 * PHASES)
        else $error("RAM write block window too long");
    cover property (!o_cpu_run && o_osc_run ##1 o_cpu_run);
    cover property ($rose(o_ram_wr_block));
    cover property (!o_osc_run);
endmodule

// File: bench/iealp_core_model.sv
// Model of the core sequencer and the timer flag sources beside the block.
`timescale 1ns/1ps
module iealp_core_model (
    input  wire logic       i_clk_sys,    // System clock.
    input  wire logic [2:0] i_fire,       // One-cycle command to pulse a timer overflow.
    input  wire logic       i_ack_en,     // Lets the core vector requests.
    input  wire logic [1:0] i_ack_wait,   // Extra cycles before the core vectors.
    input  wire logic [5:0] i_irq_req,    // Gated requests from the block.
    output logic            o_timer0_ovf, // Timer 0 overflow pulse.
    output logic            o_timer1_ovf, // Timer 1 overflow pulse.
    output logic            o_timer2_ovf, // Timer 2 rollover pulse.
    output logic            o_irq_ack     // Vectoring acknowledge.
);
    logic [1:0] wait_q; // Cycles spent before the acknowledge.
    // Quiet outputs at time zero, before the first edge.
    initial
    begin
        {o_timer0_ovf, o_timer1_ovf, o_timer2_ovf, o_irq_ack} = 4'h0;
        wait_q = 2'h0;
    end
    // Timers overflow as single-cycle pulses on the block's own clock.
    always @(posedge i_clk_sys)
        {o_timer2_ovf, o_timer1_ovf, o_timer0_ovf} <= i_fire;
    // The core vectors any request; it never clears timer 2 flags itself.
    always @(posedge i_clk_sys)
    begin
        o_irq_ack <= 1'b0;
        if (!i_ack_en || i_irq_req == 6'h00 || o_irq_ack)
            wait_q <= 2'h0;
        else if (wait_q == i_ack_wait)
            o_irq_ack <= 1'b1;
        else
            wait_q <= wait_q + 2'h1;
    end
endmodule

// File: bench/iealp_top_bench.sv
// Self-checking bench for the interrupt enable and low-power block.
`timescale 1ns/1ps
`include "iealp_params.svh"
module iealp_top_bench;
    localparam int PH = 4; // Short machine cycle keeps the run brief.
    logic       clk, rstn, wr, rd, rd_d, pa, pb, trig, ser, hwr, ackon, t0, t1, t2, ack;
    logic       cpu, osc, iclk, blk, ale, pss, p0oe, p2sel;
    logic [7:0] addr, wdata, rdata, rnd;
    logic [5:0] req;
    logic [2:0] fire;
    logic [1:0] ackw;
    logic [7:0] exp_q[$];    // Expected read data, oldest first.
    int         err_total;
    int         n_compared;
    int         n;
    wire  [7:0] pins = {2'h0, cpu, osc, ale, pss, p0oe, p2sel}; // Mode-dependent pin levels.
    iealp_top #(.PHASES(PH)) iealp_top_i (.i_clk_sys(clk), .i_resetn(rstn), .i_addr(addr), .i_wdata(wdata),
        .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_ext_irq_pin_a(pa), .i_ext_irq_pin_b(pb),
        .i_timer2_trigger_pin(trig), .i_timer0_ovf(t0), .i_timer1_ovf(t1), .i_timer2_ovf(t2),
        .i_serial_irq(ser), .i_irq_ack(ack), .i_hw_reset_req(hwr), .o_irq_req(req), .o_cpu_run(cpu),
        .o_osc_run(osc), .o_int_clk(iclk), .o_ram_wr_block(blk), .o_addr_strobe(ale),
        .o_program_store_strobe(pss), .o_port0_oe(p0oe), .o_port2_addr_sel(p2sel));
    iealp_core_model iealp_core_model_i (.i_clk_sys(clk), .i_fire(fire), .i_ack_en(ackon), .i_ack_wait(ackw),
        .i_irq_req(req), .o_timer0_ovf(t0), .o_timer1_ovf(t1), .o_timer2_ovf(t2), .o_irq_ack(ack));
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e)
        begin
            $display("unexpected %s: expected %h, seen %h", what, e, g);
            err_total++;
        end
    endtask
    // Read data stands only in the cycle after the strobe, so it is taken there.
    always @(posedge clk)
    begin
        if (rd_d)
            chk("read data", exp_q.pop_front(), rdata);
        rd_d <= rd;
    end
    // The gap cycle keeps a strobe from being driven twice in one step.
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
    endtask
    task automatic pulse(input logic [2:0] m);
        fire <= m;
        @(posedge clk);
        fire <= 3'h0;
        @(posedge clk);
    endtask
    task automatic wait_on(input logic [5:0] m);
        for (int k = 0; k < 40 && (req & m) === 6'h00; k++)
            @(posedge clk);
    endtask
    task automatic do_reset();
        rstn <= 1'b0;
        repeat (6) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
    endtask
    task automatic summarize();
        $display("compared %0d, mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // A hang counts as a mismatch and ends the run in the same place.
    initial
    begin
        repeat (20000) @(posedge clk);
        err_total++;
        summarize();
    end
    initial
    begin
        {rstn, wr, rd, ser, hwr, ackon, fire, ackw, addr, wdata} = '0;
        {pa, pb, trig} = 3'h7;
        err_total = 0;
        n_compared = 0;
        void'($urandom(32'hea1c));
        do_reset();
        rd_reg(`IEALP_ADDR_IE, `IEALP_IE_RESET);
        rnd = 8'($urandom()) | 8'h40;
        wr_reg(`IEALP_ADDR_IE, rnd);
        rd_reg(`IEALP_ADDR_IE, rnd & `IEALP_IE_MASK);
        wr_reg(8'h10, 8'hFF);
        rd_reg(8'h10, 8'h00);
        $display("register test done");
        // Each source is held off by the global enable, then served once it is set.
        for (int i = 0; i < 6; i++)
        begin
            wr_reg(`IEALP_ADDR_IE, 8'h01 << i);
            case (i)
                0: pa <= 1'b0;
                1: pulse(3'h1);
                2: pb <= 1'b0;
                3: pulse(3'h2);
                4: ser <= 1'b1;
                default: pulse(3'h4);
            endcase
            repeat (3 * PH) @(posedge clk);
            chk("masked request", 8'h00, {2'h0, req});
            wr_reg(`IEALP_ADDR_IE, 8'h80 | (8'h01 << i));
            wait_on(6'h3F);
            chk("pending request", 8'h01 << i, {2'h0, req});
            {pa, pb, ser, ackon, ackw} <= {4'hD, 2'(i)};
            repeat (4 * PH) @(posedge clk);
            ackon <= 1'b0;
            if (i == 5)
                chk("timer2 after vector", 8'h20, {2'h0, req});
            wr_reg(`IEALP_ADDR_T2CTL, 8'h00);
            repeat (2 * PH) @(posedge clk);
            chk("cleared request", 8'h00, {2'h0, req});
        end
        wr_reg(`IEALP_ADDR_T2CTL, 8'h08);
        trig <= 1'b0;
        wait_on(6'h20);
        chk("trigger request", 8'h20, {2'h0, req});
        rd_reg(`IEALP_ADDR_T2CTL, 8'h48);
        wr_reg(`IEALP_ADDR_T2CTL, 8'h10);
        trig <= 1'b1;
        pulse(3'h4);
        repeat (3 * PH) @(posedge clk);
        chk("baud rollover", 8'h00, {2'h0, req});
        $display("request test done");
        wr_reg(`IEALP_ADDR_IE, 8'h81);
        wr_reg(`IEALP_ADDR_PCTL, 8'h05);
        repeat (3) @(posedge clk);
        chk("idle pins", 8'h1D, pins);
        rd_reg(`IEALP_ADDR_STATUS, {iealp_pkg::IEALP_IDLE, 6'h00});
        rd_reg(`IEALP_ADDR_PCTL, 8'h04);
        pa <= 1'b0;
        for (int k = 0; k < 40 && cpu !== 1'b1; k++)
            @(posedge clk);
        // The address strobe toggles while the core runs, so its bit is left out here.
        chk("woken pins", 8'h37, pins & 8'hF7);
        pa <= 1'b1;
        repeat (3) @(posedge clk); // The released pin must clear the synchroniser first.
        wr_reg(`IEALP_ADDR_PCTL, 8'h01);
        repeat (3) @(posedge clk);
        hwr <= 1'b1;
        n = 0;
        for (int k = 0; k < 40 && blk !== 1'b1; k++)
            @(posedge clk);
        for (int k = 0; k < 40 && blk === 1'b1; k++)
        begin
            n++;
            @(posedge clk);
        end
        hwr <= 1'b0;
        chk("block window", 8'h01, {7'h00, n > 0 && n <= 2 * PH});
        $display("idle test done");
        wr_reg(`IEALP_ADDR_IE, 8'h81);
        wr_reg(`IEALP_ADDR_PCTL, 8'h06);
        repeat (3) @(posedge clk);
        chk("power-down pins", 8'h00, pins);
        pa <= 1'b0;
        repeat (10 * PH) @(posedge clk);
        chk("power-down held", 8'h00, pins);
        pa <= 1'b1;
        do_reset();
        chk("pins after reset", 8'h32, pins);
        rd_reg(`IEALP_ADDR_IE, `IEALP_IE_RESET);
        $display("power-down test done");
        summarize();
    end
endmodule
bind iealp_top iealp_checker #(.PHASES(PHASES)) iealp_checker_i (.i_clk_sys, .i_resetn, .i_addr, .i_wdata,
    .i_wr, .i_rd, .o_rdata, .o_irq_req, .o_cpu_run, .o_osc_run, .o_int_clk, .o_ram_wr_block, .o_addr_strobe,
    .o_program_store_strobe, .o_port0_oe, .o_port2_addr_sel);

// File: hdl/iealp_top.sv
// Interrupt enable, request gating and low-power mode control.
`timescale 1ns/1ps
`include "iealp_params.svh"
module iealp_top #(
    parameter int PHASES = `IEALP_PHASES
) (
    input  wire logic       i_clk_sys,          // System clock, 200 MHz.
    input  wire logic       i_resetn,           // Synchronous reset, active low.
    input  wire logic [7:0] i_addr,             // Register address.
    input  wire logic [7:0] i_wdata,            // Register write data.
    input  wire logic       i_wr,               // Write strobe.
    input  wire logic       i_rd,               // Read strobe.
    output logic      [7:0] o_rdata,            // Read data, one cycle after the strobe.
    input  wire logic       i_ext_irq_pin_a,    // External interrupt pin A, active low.
    input  wire logic       i_ext_irq_pin_b,    // External interrupt pin B, active low.
    input  wire logic       i_timer2_trigger_pin, // Timer 2 trigger pin.
    input  wire logic       i_timer0_ovf,       // Timer 0 overflow pulse.
    input  wire logic       i_timer1_ovf,       // Timer 1 overflow pulse.
    input  wire logic       i_timer2_ovf,       // Timer 2 rollover pulse.
    input  wire logic       i_serial_irq,       // Serial port request level.
    input  wire logic       i_irq_ack,          // Core acknowledges the request.
    input  wire logic       i_hw_reset_req,     // Hardware reset request pin level.
    output logic      [5:0] o_irq_req,          // Gated requests to the core.
    output logic            o_cpu_run,          // CPU clock enable.
    output logic            o_osc_run,          // Oscillator enable.
    output logic            o_int_clk,          // Internal clock, oscillator divided by two.
    output logic            o_ram_wr_block,     // Blocks internal RAM writes.
    output logic            o_addr_strobe,      // Address latch strobe pin.
    output logic            o_program_store_strobe, // Program store strobe pin.
    output logic            o_port0_oe,         // Port 0 drive enable.
    output logic            o_port2_addr_sel    // Port 2 drives address when high.
);
    // The phase counter is eight bits wide and needs at least two phases.
    if (PHASES < 2 || PHASES > 255)
    begin : g_phase_check
        $error("PHASES out of range");
    end

    // Registers.
    logic [7:0] interrupt_enable_reg_q;          // Enable register.
    logic       timer2_overflow_flag_q;          // Timer 2 overflow flag.
    logic       timer2_external_event_flag_q;    // Timer 2 event flag.
    logic       exen_q;                          // External trigger enable.
    logic       baud_mode_q;                     // Timer 2 in baud rate mode.
    logic       ext_mem_q;                       // External program memory in use.
    logic       timer0_overflow_flag_q;          // Timer 0 flag.
    logic       timer1_overflow_flag_q;          // Timer 1 flag.
    logic       t0_poll_q;                       // Timer 0 flag as polled.
    logic       t1_poll_q;                       // Timer 1 flag as polled.
    iealp_pkg::iealp_mode_type mode_q;           // Low-power mode.
    logic [7:0] phase_q;                         // Machine cycle phase counter.
    logic [1:0] wake_q;                          // Cycles run after reset exits idle.
    logic       div_q;                           // Divide-by-two flip-flop.
    // Synchronisers: stage one feeds only stage two.
    logic [3:0] sync1_q;
    logic [3:0] sync2_q;
    logic       trig_prev_q;                     // Previous synchronised trigger level.
    logic       rst_prev_q;                      // Previous synchronised reset request.

    // Pins cross two flip-flops before use.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            sync1_q <= 4'h7; // Idle pin levels, so no false edge follows reset.
            sync2_q <= 4'h7; // Idle pin levels, so no false edge follows reset.
        end
        else
        begin
            sync1_q <= {i_hw_reset_req, i_timer2_trigger_pin, i_ext_irq_pin_b, i_ext_irq_pin_a};
            sync2_q <= sync1_q;
        end
    end

    // Decoded strobes.
    logic wr_ie;
    logic wr_t2;
    logic wr_pc;
    assign wr_ie = i_wr && (i_addr == `IEALP_ADDR_IE);
    assign wr_t2 = i_wr && (i_addr == `IEALP_ADDR_T2CTL);
    assign wr_pc = i_wr && (i_addr == `IEALP_ADDR_PCTL);

    // Machine cycle boundary; flag polling is aligned to it.
    logic cycle_end;
    assign cycle_end = (phase_q == 8'(PHASES - 1));

    // The internal clock is a toggle, so the source duty cycle never matters.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
            div_q <= 1'b0;
        else if (mode_q != iealp_pkg::IEALP_PDOWN)
            div_q <= ~div_q;
    end

    // Phase counter runs in idle too, so the interrupt system keeps working.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
            phase_q <= 8'h00;
        else if (mode_q == iealp_pkg::IEALP_PDOWN)
            phase_q <= phase_q;
        else if (cycle_end)
            phase_q <= 8'h00;
        else
            phase_q <= phase_q + 8'h01;
    end

    // Enable register; reserved bit 6 is not stored, which protects against stray writes.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
            interrupt_enable_reg_q <= `IEALP_IE_RESET;
        else if (wr_ie)
            interrupt_enable_reg_q <= i_wdata & `IEALP_IE_MASK;
    end

    // Timer 2 configuration bits.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            exen_q      <= 1'b0;
            baud_mode_q <= 1'b0;
        end
        else if (wr_t2)
        begin
            exen_q      <= i_wdata[`IEALP_BIT_EXEN2];
            baud_mode_q <= i_wdata[`IEALP_BIT_BAUD];
        end
    end

    // Timer 2 flags; hardware set wins over a software clear in the same cycle.
    logic trig_fall;
    assign trig_fall = trig_prev_q && !sync2_q[2];
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            timer2_overflow_flag_q       <= 1'b0;
            timer2_external_event_flag_q <= 1'b0;
            trig_prev_q                  <= 1'b1;
        end
        else
        begin
            trig_prev_q <= sync2_q[2];
            // Baud rate rollovers never touch the overflow flag.
            if (i_timer2_ovf && !baud_mode_q)
                timer2_overflow_flag_q <= 1'b1;
            else if (wr_t2)
                timer2_overflow_flag_q <= i_wdata[`IEALP_BIT_T2F];
            if (exen_q && trig_fall)
                timer2_external_event_flag_q <= 1'b1;
            else if (wr_t2)
                timer2_external_event_flag_q <= i_wdata[`IEALP_BIT_T2EXF];
        end
    end

    // Timer 0/1 flags are set now and only polled at the next cycle boundary.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            timer0_overflow_flag_q <= 1'b0;
            timer1_overflow_flag_q <= 1'b0;
            t0_poll_q              <= 1'b0;
            t1_poll_q              <= 1'b0;
        end
        else
        begin
            // The core clears these on acknowledge; a new overflow wins.
            if (i_timer0_ovf)
                timer0_overflow_flag_q <= 1'b1;
            else if (i_irq_ack && o_irq_req[1])
                timer0_overflow_flag_q <= 1'b0;
            if (i_timer1_ovf)
                timer1_overflow_flag_q <= 1'b1;
            else if (i_irq_ack && o_irq_req[3])
                timer1_overflow_flag_q <= 1'b0;
            if (cycle_end)
            begin
                // An acknowledge on the boundary must not poll the flag it is clearing.
                t0_poll_q <= timer0_overflow_flag_q && !(i_irq_ack && o_irq_req[1]);
                t1_poll_q <= timer1_overflow_flag_q && !(i_irq_ack && o_irq_req[3]);
            end
            else
            begin
                if (i_irq_ack && o_irq_req[1])
                    t0_poll_q <= 1'b0;
                if (i_irq_ack && o_irq_req[3])
                    t1_poll_q <= 1'b0;
            end
        end
    end

    // Raw requests in enable bit order; pending flags stay set while masked.
    logic [5:0] raw_req;
    logic [5:0] gated_req;
    assign raw_req = {timer2_overflow_flag_q | timer2_external_event_flag_q,
                      i_serial_irq, t1_poll_q, ~sync2_q[1], t0_poll_q, ~sync2_q[0]};
    assign gated_req = interrupt_enable_reg_q[`IEALP_BIT_GLOBAL]
                       ? (raw_req & interrupt_enable_reg_q[5:0]) : 6'h00;

    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
            o_irq_req <= 6'h00;
        else
            o_irq_req <= gated_req;
    end

    // Mode control; pins go to their idle or power-down levels.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            mode_q    <= iealp_pkg::IEALP_RUN;
            ext_mem_q <= 1'b0;
            rst_prev_q <= 1'b0;
            wake_q    <= 2'h0;
        end
        else
        begin
            rst_prev_q <= sync2_q[3];
            if (wr_pc)
                ext_mem_q <= i_wdata[2];
            case (mode_q)
                iealp_pkg::IEALP_RUN:
                begin
                    if (wake_q != 2'h0 && cycle_end)
                        wake_q <= wake_q - 2'h1;
                    if (wr_pc && i_wdata[`IEALP_PCTL_PDOWN])
                        mode_q <= iealp_pkg::IEALP_PDOWN;
                    else if (wr_pc && i_wdata[`IEALP_PCTL_IDLE])
                        mode_q <= iealp_pkg::IEALP_IDLE;
                end
                iealp_pkg::IEALP_IDLE:
                begin
                    if (gated_req != 6'h00)
                        mode_q <= iealp_pkg::IEALP_RUN;
                    else if (sync2_q[3] && !rst_prev_q)
                    begin
                        mode_q <= iealp_pkg::IEALP_RUN;
                        wake_q <= 2'(`IEALP_WAKE_CYCLES);
                    end
                end
                iealp_pkg::IEALP_PDOWN:
                begin
                    mode_q <= iealp_pkg::IEALP_PDOWN;
                end
                default:
                    mode_q <= iealp_pkg::IEALP_RUN;
            endcase
        end
    end

    // Registered outputs that follow the mode.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
        begin
            o_cpu_run              <= 1'b1;
            o_osc_run              <= 1'b1;
            o_int_clk              <= 1'b0;
            o_ram_wr_block         <= 1'b0;
            o_addr_strobe          <= 1'b0;
            o_program_store_strobe <= 1'b0;
            o_port0_oe             <= 1'b1;
            o_port2_addr_sel       <= 1'b0;
        end
        else
        begin
            o_cpu_run      <= (mode_q == iealp_pkg::IEALP_RUN);
            o_osc_run      <= (mode_q != iealp_pkg::IEALP_PDOWN);
            o_int_clk      <= div_q;
            o_ram_wr_block <= (wake_q != 2'h0);
            case (mode_q)
                iealp_pkg::IEALP_IDLE:
                begin
                    o_addr_strobe          <= 1'b1;
                    o_program_store_strobe <= 1'b1;
                    o_port0_oe             <= !ext_mem_q;
                    o_port2_addr_sel       <= ext_mem_q;
                end
                iealp_pkg::IEALP_PDOWN:
                begin
                    o_addr_strobe          <= 1'b0;
                    o_program_store_strobe <= 1'b0;
                    o_port0_oe             <= !ext_mem_q;
                    o_port2_addr_sel       <= 1'b0;
                end
                default:
                begin
                    o_addr_strobe          <= div_q;
                    o_program_store_strobe <= 1'b1;
                    o_port0_oe             <= 1'b1;
                    o_port2_addr_sel       <= ext_mem_q;
                end
            endcase
        end
    end

    // Read data, valid only in the cycle after the read strobe.
    always_ff @(posedge i_clk_sys)
    begin
        if (!i_resetn)
            o_rdata <= 8'h00;
        else if (!i_rd)
            o_rdata <= 8'h00;
        else if (i_addr == `IEALP_ADDR_IE)
            o_rdata <= interrupt_enable_reg_q;
        else if (i_addr == `IEALP_ADDR_T2CTL)
            o_rdata <= {timer2_overflow_flag_q, timer2_external_event_flag_q, 2'b00,
                        exen_q, baud_mode_q ? 1'b1 : 1'b0, 2'b00} & 8'hD8 | {3'b000, baud_mode_q, 4'h0};
        else if (i_addr == `IEALP_ADDR_PCTL)
            o_rdata <= {5'h00, ext_mem_q, 2'b00};
        else if (i_addr == `IEALP_ADDR_STATUS)
            o_rdata <= {mode_q, raw_req};
        else
            o_rdata <= 8'h00;
    end
endmodule

// File: include/iealp_params.svh
// Constants for the interrupt enable and low-power control block.
`ifndef IEALP_PARAMS_SVH
`define IEALP_PARAMS_SVH
`define IEALP_ADDR_IE      8'h00
`define IEALP_ADDR_T2CTL   8'h01
`define IEALP_ADDR_PCTL    8'h02
`define IEALP_ADDR_STATUS  8'h03
`define IEALP_IE_RESET     8'h00
`define IEALP_IE_MASK      8'hBF
`define IEALP_BIT_GLOBAL   7
`define IEALP_BIT_T2F      7
`define IEALP_BIT_T2EXF    6
`define IEALP_BIT_EXEN2    3
`define IEALP_BIT_BAUD     4
`define IEALP_PCTL_IDLE    0
`define IEALP_PCTL_PDOWN   1
`define IEALP_PHASES       12
`define IEALP_WAKE_CYCLES  2
`endif

// File: include/iealp_pkg.sv
// Types for the interrupt enable and low-power control block.
package iealp_pkg;
    typedef enum logic [1:0] {
        IEALP_RUN,
        IEALP_IDLE,
        IEALP_PDOWN
    } iealp_mode_type;
endpackage
